// ### system_bus_pin_interface.sv
// module: pin-level sequencer for the shared external system bus
`timescale 1ns/1ns
module system_bus_pin_interface #(
    parameter int ADDR_W = sysbus_pkg::ADDR_W,
    parameter int DATA_W = sysbus_pkg::DATA_W
)(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire sysbus_pkg::bus_req_t req,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    output logic [DATA_W-1:0]         rsp_data,
    output logic                      rsp_valid,
    input  wire logic                 card_reset_req,
    output logic                      card_irq,
    output logic [ADDR_W-1:0]         addr_out,
    input  wire logic [DATA_W-1:0]    data_in,
    output logic [DATA_W-1:0]         data_out,
    output logic                      data_oe,
    output logic                      panel_sel_n,
    output logic                      panel_rd_n,
    output logic                      shared_wr_n,
    input  wire logic                 target_rdy,
    output logic [3:0]                boot_mem_sel_n,
    output logic                      boot_mem_rd_n,
    output logic [3:0]                dram_row_strobe_n,
    output logic                      dram_col_hi_n,
    output logic                      dram_col_lo_n,
    output logic                      dram_wr_n,
    output logic                      card_clk,
    output logic                      card_hi_byte_en_n,
    output logic                      card_io_rd_n,
    output logic                      card_io_wr_n,
    output logic                      card_mem_rd_n,
    output logic                      card_mem_wr_n,
    input  wire logic                 card_no_wait_n,
    input  wire logic                 card_irq_in,
    output logic                      card_rst_n
);

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'h0,
        ST_ROW   = 3'h1,
        ST_COL   = 3'h2,
        ST_STRB  = 3'h3,
        ST_WAIT  = 3'h4,
        ST_DONE  = 3'h5
    } state_t;

    state_t               state_reg;
    sysbus_pkg::bus_req_t cur_reg;
    logic [7:0]           cnt_reg;
    logic [1:0]           rdy_sync_reg;
    logic [1:0]           zws_sync_reg;
    logic [1:0]           irq_sync_reg;
    logic [3:0]           div_reg;
    logic                 card_clk_reg;
    logic                 strobe_on;
    logic                 rd;
    logic                 wr;
    logic                 waits_ok;
    logic                 is_card;

    // ========================================
    // input synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rdy_sync_reg <= 2'h0;
            zws_sync_reg <= 2'h3;
            irq_sync_reg <= 2'h0;
        end
        else
        begin
            rdy_sync_reg <= {rdy_sync_reg[0], target_rdy};
            zws_sync_reg <= {zws_sync_reg[0], card_no_wait_n};
            irq_sync_reg <= {irq_sync_reg[0], card_irq_in};
        end
    end

    assign card_irq = irq_sync_reg[1];

    // ========================================
    // card clock divider
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            div_reg      <= 4'h0;
            card_clk_reg <= 1'b0;
        end
        else if (div_reg == 4'(sysbus_pkg::CARD_HALF - 1))
        begin
            div_reg      <= 4'h0;
            card_clk_reg <= ~card_clk_reg;
        end
        else
        begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign card_clk = card_clk_reg;

    // ========================================
    // access sequencer
    assign is_card  = (cur_reg.target == sysbus_pkg::TGT_CARD_M) ||
                      (cur_reg.target == sysbus_pkg::TGT_CARD_I);
    assign waits_ok = rdy_sync_reg[1] ||
                      (is_card && !zws_sync_reg[1]);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            cur_reg   <= '0;
            cnt_reg   <= 8'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    cnt_reg <= 8'h0;
                    if (req_valid)
                    begin
                        cur_reg <= req;
                        if (req.target == sysbus_pkg::TGT_DRAM)
                            state_reg <= ST_ROW;
                        else
                            state_reg <= ST_STRB;
                    end
                end
                ST_ROW:
                begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == 8'(sysbus_pkg::DRAM_RAS_CYC - 1))
                    begin
                        cnt_reg   <= 8'h0;
                        state_reg <= ST_COL;
                    end
                end
                ST_COL:
                begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == 8'(sysbus_pkg::DRAM_CAS_CYC - 1))
                        state_reg <= ST_DONE;
                end
                ST_STRB:
                begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == 8'(sysbus_pkg::STROBE_CYC - 1))
                    begin
                        cnt_reg <= 8'h0;
                        if (cur_reg.target == sysbus_pkg::TGT_ROM)
                            state_reg <= ST_DONE;
                        else
                            state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (waits_ok ||
                        cnt_reg == 8'(sysbus_pkg::WAIT_MAX))
                        state_reg <= ST_DONE;
                end
                ST_DONE:
                begin
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // read data capture
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rsp_data  <= '0;
            rsp_valid <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state_reg == ST_DONE) && !cur_reg.write;
            if (state_reg == ST_DONE && !cur_reg.write)
                rsp_data <= data_in;
        end
    end

    assign req_ready = (state_reg == ST_IDLE);

    // ========================================
    // pin decode, one target at a time
    assign strobe_on = (state_reg == ST_STRB) || (state_reg == ST_WAIT);
    assign rd        = !cur_reg.write;
    assign wr        = cur_reg.write;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            addr_out          <= '0;
            data_out          <= '0;
            data_oe           <= 1'b0;
            panel_sel_n       <= 1'b1;
            panel_rd_n        <= 1'b1;
            shared_wr_n       <= 1'b1;
            boot_mem_sel_n    <= 4'hf;
            boot_mem_rd_n     <= 1'b1;
            dram_row_strobe_n <= 4'hf;
            dram_col_hi_n     <= 1'b1;
            dram_col_lo_n     <= 1'b1;
            dram_wr_n         <= 1'b1;
            card_hi_byte_en_n <= 1'b1;
            card_io_rd_n      <= 1'b1;
            card_io_wr_n      <= 1'b1;
            card_mem_rd_n     <= 1'b1;
            card_mem_wr_n     <= 1'b1;
            card_rst_n        <= 1'b0;
        end
        else
        begin
            card_rst_n <= !card_reset_req;
            panel_sel_n       <= 1'b1;
            panel_rd_n        <= 1'b1;
            shared_wr_n       <= 1'b1;
            boot_mem_sel_n    <= 4'hf;
            boot_mem_rd_n     <= 1'b1;
            dram_row_strobe_n <= 4'hf;
            dram_col_hi_n     <= 1'b1;
            dram_col_lo_n     <= 1'b1;
            dram_wr_n         <= 1'b1;
            card_hi_byte_en_n <= 1'b1;
            card_io_rd_n      <= 1'b1;
            card_io_wr_n      <= 1'b1;
            card_mem_rd_n     <= 1'b1;
            card_mem_wr_n     <= 1'b1;
            data_oe           <= 1'b0;
            if (state_reg == ST_IDLE && req_valid)
            begin
                if (req.target == sysbus_pkg::TGT_DRAM)
                    addr_out <= req.row;
                else
                    addr_out <= req.addr;
                data_out <= req.wdata;
            end
            else if (state_reg == ST_ROW &&
                     cnt_reg == 8'(sysbus_pkg::DRAM_RAS_CYC - 1))
                addr_out <= cur_reg.addr;
            if (state_reg == ST_ROW || state_reg == ST_COL)
            begin
                dram_row_strobe_n[cur_reg.bank] <= 1'b0;
                if (state_reg == ST_COL)
                begin
                    dram_col_hi_n <= !cur_reg.byte_en[1];
                    dram_col_lo_n <= !cur_reg.byte_en[0];
                    dram_wr_n     <= !wr;
                    data_oe       <= wr;
                end
            end
            else if (strobe_on)
            begin
                data_oe <= wr;
                case (cur_reg.target)
                    sysbus_pkg::TGT_ROM:
                    begin
                        boot_mem_sel_n[cur_reg.bank] <= 1'b0;
                        boot_mem_rd_n <= !rd;
                        shared_wr_n   <= !wr;
                    end
                    sysbus_pkg::TGT_PANEL:
                    begin
                        panel_sel_n <= 1'b0;
                        panel_rd_n  <= !rd;
                        shared_wr_n <= !wr;
                    end
                    sysbus_pkg::TGT_CARD_M:
                    begin
                        card_hi_byte_en_n <= !cur_reg.byte_en[1];
                        card_mem_rd_n     <= !rd;
                        card_mem_wr_n     <= !wr;
                    end
                    sysbus_pkg::TGT_CARD_I:
                    begin
                        card_hi_byte_en_n <= !cur_reg.byte_en[1];
                        card_io_rd_n      <= !rd;
                        card_io_wr_n      <= !wr;
                    end
                    default:
                    begin
                        data_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// ### sysbus_pkg.sv
// package: shared types and constants for the external system bus pins
package sysbus_pkg;

    localparam int ADDR_W       = 21;
    localparam int DATA_W       = 16;
    localparam int BANKS        = 4;
    localparam int SYS_CLK_KHZ  = 125000;
    localparam int CARD_CLK_KHZ = 8000;
    // half period of the card clock, in system cycles
    localparam int CARD_HALF    = SYS_CLK_KHZ / (2 * CARD_CLK_KHZ);
    localparam int DRAM_RAS_CYC = 2;
    localparam int DRAM_CAS_CYC = 2;
    localparam int STROBE_CYC   = 3;
    localparam int WAIT_MAX     = 255;

    typedef enum logic [2:0]
    {
        TGT_DRAM   = 3'h0,
        TGT_ROM    = 3'h1,
        TGT_PANEL  = 3'h2,
        TGT_CARD_M = 3'h3,
        TGT_CARD_I = 3'h4
    } target_t;

    typedef struct packed
    {
        target_t             target;
        logic                write;
        logic [1:0]          bank;
        logic [1:0]          byte_en;
        logic [ADDR_W-1:0]   row;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } bus_req_t;

endpackage

// ### sysbus_properties.sv
// checker: pin exclusivity and timing properties of the system bus
`timescale 1ns/1ns
module sysbus_properties (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       card_reset_req,
    input wire logic       panel_sel_n,
    input wire logic       panel_rd_n,
    input wire logic       shared_wr_n,
    input wire logic [3:0] boot_mem_sel_n,
    input wire logic       boot_mem_rd_n,
    input wire logic [3:0] dram_row_strobe_n,
    input wire logic       dram_col_hi_n,
    input wire logic       dram_col_lo_n,
    input wire logic       dram_wr_n,
    input wire logic       card_clk,
    input wire logic       card_io_rd_n,
    input wire logic       card_io_wr_n,
    input wire logic       card_mem_rd_n,
    input wire logic       card_mem_wr_n,
    input wire logic       card_rst_n
);
    // ========================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire card_on = !(card_io_rd_n & card_io_wr_n
                     & card_mem_rd_n & card_mem_wr_n);
    wire dram_on = dram_row_strobe_n != 4'hf;
    wire boot_on = boot_mem_sel_n != 4'hf;
    wire col_on  = !(dram_col_hi_n & dram_col_lo_n);
    a_target_excl: assert property (
        $countones({!panel_sel_n, boot_on, dram_on, card_on}) <= 1)
        else $error("two targets selected");
    a_boot_onehot: assert property (
        $countones(~boot_mem_sel_n) <= 1) else $error("boot selects");
    a_row_onehot: assert property (
        $countones(~dram_row_strobe_n) <= 1) else $error("row strobes");
    a_card_strb_one: assert property (
        $countones({card_io_rd_n, card_io_wr_n, card_mem_rd_n,
                    card_mem_wr_n}) >= 3) else $error("card strobes");
    a_panel_rd_sel: assert property (
        !panel_rd_n |-> !panel_sel_n) else $error("panel read unselected");
    a_boot_rd_sel: assert property (
        !boot_mem_rd_n |-> boot_on) else $error("boot read unselected");
    a_shared_wr_tgt: assert property (
        !shared_wr_n |-> !panel_sel_n || boot_on)
        else $error("shared write without target");
    a_col_after_row: assert property (
        col_on |-> dram_on && $past(dram_on)) else $error("column early");
    a_dram_wr_col: assert property (
        !dram_wr_n |-> col_on) else $error("dram write outside column");
    a_card_clk_half: assert property (
        $changed(card_clk) |=> $stable(card_clk)[*6] ##1 $changed(card_clk))
        else $error("card clock half period");
    a_card_rst_dly: assert property (
        !$past(rst) |-> card_rst_n == !$past(card_reset_req))
        else $error("card reset follow");
    a_wait_bound: assert property (
        $fell(panel_sel_n) |-> ##[3:270] $rose(panel_sel_n))
        else $error("panel access length");
    c_col_write: cover property (col_on && !dram_wr_n);
    c_panel_end: cover property ($rose(panel_sel_n));
    c_card_io_rd: cover property (!card_io_rd_n);
endmodule

bind system_bus_pin_interface sysbus_properties sysbus_properties_i (
    .sys_clk, .rst, .card_reset_req, .panel_sel_n, .panel_rd_n,
    .shared_wr_n, .boot_mem_sel_n, .boot_mem_rd_n, .dram_row_strobe_n,
    .dram_col_hi_n, .dram_col_lo_n, .dram_wr_n, .card_clk, .card_io_rd_n,
    .card_io_wr_n, .card_mem_rd_n, .card_mem_wr_n, .card_rst_n);

// ### sysbus_partner.sv
// partner: far-side targets answering the system bus pins
`timescale 1ns/1ns
module sysbus_partner (
    input  wire logic        lk_clk,
    input  wire logic [7:0]  rdy_dly,
    input  wire logic        nw_mode,
    input  wire logic        irq_req,
    input  wire logic [20:0] addr_out,
    input  wire logic        panel_sel_n,
    input  wire logic        panel_rd_n,
    input  wire logic        boot_mem_rd_n,
    input  wire logic        dram_col_hi_n,
    input  wire logic        dram_col_lo_n,
    input  wire logic        dram_wr_n,
    input  wire logic        card_io_rd_n,
    input  wire logic        card_io_wr_n,
    input  wire logic        card_mem_rd_n,
    input  wire logic        card_mem_wr_n,
    output logic [15:0]      data_in,
    output logic             target_rdy,
    output logic             card_no_wait_n,
    output logic             card_irq_in = 1'b0
);
    // ========================================
    // target responses
    logic [7:0]  cnt = 8'h0;
    logic [15:0] last_rd = 16'h0;
    wire card_on = !(card_io_rd_n & card_io_wr_n
                     & card_mem_rd_n & card_mem_wr_n);
    wire act = !panel_sel_n || card_on;
    wire rd = !(panel_rd_n & boot_mem_rd_n & card_io_rd_n & card_mem_rd_n)
              || (!(dram_col_hi_n & dram_col_lo_n) && dram_wr_n);
    always @(posedge lk_clk or negedge act)
        if (!act) cnt <= 8'h0;
        else if (cnt != 8'hff) cnt <= cnt + 8'h1;
    always @*
        if (rd) last_rd = addr_out[15:0] ^ 16'h5a5a;
    assign data_in = rd ? addr_out[15:0] ^ 16'h5a5a : ~last_rd;
    assign target_rdy = act && cnt >= rdy_dly;
    assign card_no_wait_n = !(card_on && nw_mode);
    always @(posedge lk_clk)
        card_irq_in <= irq_req;
endmodule

// ### system_bus_pin_interface_tb.sv
// testbench: random accesses over all bus targets, wait corner accesses on panel and card I/O only
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module system_bus_pin_interface_tb;
    logic sys_clk = 1'b0, rst = 1'b1, lk_clk = 1'b0, req_valid = 1'b0;
    logic card_reset_req = 1'b0, nw_mode = 1'b0, irq_req = 1'b0;
    logic req_ready, rsp_valid, card_irq, data_oe, panel_sel_n, panel_rd_n;
    logic shared_wr_n, target_rdy, boot_mem_rd_n, dram_col_hi_n;
    logic dram_col_lo_n, dram_wr_n, card_clk, card_hi_byte_en_n;
    logic card_io_rd_n, card_io_wr_n, card_mem_rd_n, card_mem_wr_n;
    logic card_no_wait_n, card_irq_in, card_rst_n;
    logic [3:0]  boot_mem_sel_n, dram_row_strobe_n;
    logic [15:0] rsp_data, data_in, data_out;
    logic [20:0] addr_out;
    logic [7:0]  rdy_dly = 8'h0;
    sysbus_pkg::bus_req_t req = '0;
    int n_fail = 0, checks_done = 0, seed = 17783, cyc = 0, n_rise = 0;
    int k, n;
    system_bus_pin_interface system_bus_pin_interface_i (.*);
    sysbus_partner sysbus_partner_i (.*);
    always #4 sys_clk = ~sys_clk;
    initial
    begin
        #3;
        forever #32 lk_clk = ~lk_clk;
    end
    always @(posedge card_clk) n_rise++;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // ========================================
    // expectations and drivers
    function automatic logic [19:0] exp_pins(sysbus_pkg::bus_req_t r);
        logic       w;
        logic [4:0] t;
        w = r.write;
        for (int i = 0; i < 5; i++)
            t[i] = r.target == sysbus_pkg::target_t'(i);
        return {t[1] ? 4'h1 << r.bank : 4'h0, t[0] ? 4'h1 << r.bank : 4'h0,
                t[2], t[2] & !w, (t[1] | t[2]) & w, t[1] & !w, t[0] & w,
                t[0] & r.byte_en[1], t[0] & r.byte_en[0],
                (t[3] | t[4]) & r.byte_en[1], t[4] & !w, t[4] & w,
                t[3] & !w, t[3] & w};
    endfunction
    task automatic rand_access(input int t);
        sysbus_pkg::bus_req_t r;
        logic [19:0] obs;
        logic [19:0] ep;
        logic [20:0] ra;
        logic [15:0] wd, rdat;
        logic        got;
        logic        oe;
        r.target = sysbus_pkg::target_t'(t);
        r.write = 1'($random(seed));
        r.bank = 2'($random(seed));
        r.byte_en = 2'($random(seed));
        if (r.byte_en == 2'h0) r.byte_en = 2'h3;
        r.row = 21'($random(seed));
        r.addr = 21'($random(seed));
        r.wdata = 16'($random(seed));
        obs = '0;
        wd = ~r.wdata;
        rdat = ~(r.addr[15:0] ^ 16'h5a5a);
        got = 1'b0;
        ra = ~r.row;
        oe = 1'b0;
        ep = exp_pins(r);
        k = 0;
        req <= r;
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        do
        begin
            @(negedge sys_clk);
            k++;
            if (obs[15:12] == 4'h0 && dram_row_strobe_n != 4'hf)
                ra = addr_out;
            oe |= data_oe;
            obs |= {~boot_mem_sel_n, ~dram_row_strobe_n, !panel_sel_n,
                    !panel_rd_n, !shared_wr_n, !boot_mem_rd_n, !dram_wr_n,
                    !dram_col_hi_n, !dram_col_lo_n, !card_hi_byte_en_n,
                    !card_io_rd_n, !card_io_wr_n, !card_mem_rd_n,
                    !card_mem_wr_n};
            if (data_oe && !(shared_wr_n & dram_wr_n & card_io_wr_n
                             & card_mem_wr_n)) wd = data_out;
            if (rsp_valid === 1'b1) rdat = rsp_data;
            if (rsp_valid === 1'b1) got = 1'b1;
        end
        while (k < 300 && !(req_ready === 1'b1 && (r.write || got)));
        @(posedge sys_clk);
        `CHK("boot_sel", ep[19:16], obs[19:16])
        `CHK("row_strobe", ep[15:12], obs[15:12])
        `CHK("panel", ep[11:9], obs[11:9])
        `CHK("boot_rd", ep[8], obs[8])
        `CHK("dram", ep[7:5], obs[7:5])
        `CHK("card", ep[4:0], obs[4:0])
        `CHK("data_oe", r.write, oe)
        `CHK("done", 1'b1, k < 300)
        if (r.target == sysbus_pkg::TGT_DRAM)
            `CHK("row_addr", r.row, ra)
        if (r.write) `CHK("wdata", r.wdata, wd)
        else `CHK("rdata", r.addr[15:0] ^ 16'h5a5a, rdat)
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========================================
    // test sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        n = n_rise;
        repeat (112) @(posedge sys_clk);
        `CHK("card_clk", 8, n_rise - n)
        $display("test clock done");
        card_reset_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("card_rst_n", 1'b0, card_rst_n)
        card_reset_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("card_rst_n", 1'b1, card_rst_n)
        irq_req <= 1'b1;
        repeat (24) @(posedge sys_clk);
        `CHK("card_irq", 1'b1, card_irq)
        irq_req <= 1'b0;
        repeat (24) @(posedge sys_clk);
        `CHK("card_irq", 1'b0, card_irq)
        $display("test reset and irq done");
        for (int t = 0; t < 5; t++)
            repeat (8)
            begin
                rdy_dly <= 8'($random(seed)) & 8'h07;
                rand_access(t);
            end
        $display("test random done");
        rdy_dly <= 8'h28;
        rand_access(2);
        `CHK("wait_timeout", 1'b1, k > 255)
        nw_mode <= 1'b1;
        rand_access(4);
        `CHK("no_wait", 1'b1, k < 40)
        $display("test wait corners done");
        finish_test();
    end
endmodule
